//--- src/bms_pkg.sv
package bms_pkg;
    // System clock rate
    localparam int unsigned CLK_HZ = 10_000_000;
    // Restart delay after reset release, in milliseconds
    localparam int unsigned T_RESTART_MS = 3;
    // Short serial window, in milliseconds
    localparam int unsigned T_SER_SHORT_MS = 100;
    // Long serial window, in seconds
    localparam int unsigned T_SER_LONG_S = 60;
    // Derived cycle counts (all three become top parameters)
    localparam logic [31:0] RESTART_CYC = 32'(T_RESTART_MS * (CLK_HZ / 1000));
    localparam logic [31:0] SER_SHORT_CYC = 32'(T_SER_SHORT_MS * (CLK_HZ / 1000));
    localparam logic [31:0] SER_LONG_CYC = 32'(64'(T_SER_LONG_S) * 64'(CLK_HZ));
    // Cycles a probe level is driven, then left to settle
    localparam logic [31:0] PROBE_CYC = 32'h0000_0004;
    // Boot memory: 16 MB addressed bytewise
    localparam int unsigned FLASH_MBYTES = 16;
    localparam int unsigned FLASH_ADDR_W = 24;
    localparam logic [FLASH_ADDR_W-1:0] FLASH_LAST_ADDR =
        FLASH_ADDR_W'(FLASH_MBYTES * 1024 * 1024 - 1);
    // Timer load width
    localparam int unsigned TMR_W = 32;

    // Boot sequencer states
    typedef enum logic [3:0] {
        ST_HOLD,
        ST_DRV_LO,
        ST_REL_LO,
        ST_DRV_HI,
        ST_REL_HI,
        ST_DECIDE,
        ST_SER_SHORT,
        ST_FLASH,
        ST_CARD,
        ST_SER_LONG,
        ST_RUN,
        ST_SHUTDOWN
    } bms_state_t;
endpackage

//--- src/bms_tmr_if.sv
`timescale 1ns/100ps
interface bms_tmr_if;
    import bms_pkg::*;
    logic start;
    logic [TMR_W-1:0] load;
    logic expired;
    logic busy;
    modport owner (output start, output load, input expired, input busy);
    modport timer (input start, input load, output expired, output busy);
endinterface

//--- src/bms_timer.sv
`timescale 1ns/100ps
module bms_timer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control from the sequencer
    bms_tmr_if.timer tmr
);
    import bms_pkg::*;

    logic [TMR_W-1:0] count_r;
    logic busy_r;
    logic expired_r;

    ////////////////////////////////////////////////////////////////////////
    // Down counter; expired pulses `load` cycles after the start edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_r <= '0;
            busy_r <= 1'b0;
            expired_r <= 1'b0;
        end else begin
            expired_r <= 1'b0;
            if (tmr.start) begin
                // A restart discards any window still running
                count_r <= tmr.load;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                if (count_r <= TMR_W'(1)) begin
                    busy_r <= 1'b0;
                    expired_r <= 1'b1;
                end else begin
                    count_r <= count_r - TMR_W'(1);
                end
            end
        end
    end

    assign tmr.expired = expired_r;
    assign tmr.busy = busy_r;
endmodule

//--- src/bms_boot_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// R01: Every reset reruns switch evaluation and boot.
// R02: All off, no card: 60 s serial.
// R03: Up on, down off: 60 s serial only.
// R04: Flash only: 100 ms serial, flash, 60 s.
// R05: Flash and down: flash only, else shutdown.
// R06: All off, card present: card, then 60 s.
// R07: Down only: card only, else shutdown.
// R08: Up pulls sense pin high, down low.
// R09: Host never sets up and down together.
// R10: Card pins: datain/detect, dataout, select, clock.
// R11: Boot memory is SPI, 16 MB.
// R12: LED lights while its pin is high.
// R13: LED power switch gates both LEDs.
// R14: Software must give LED pins defined levels.
// R15: Reset floats pins; restart 3 ms later.
// R16: Switches sampled once; pins freed after boot.
module bms_boot_ctrl #(
    parameter logic [31:0] RESTART_CYC_P = bms_pkg::RESTART_CYC,
    parameter logic [31:0] SER_SHORT_CYC_P = bms_pkg::SER_SHORT_CYC,
    parameter logic [31:0] SER_LONG_CYC_P = bms_pkg::SER_LONG_CYC
) (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    // Configuration switches (asynchronous)
    input wire logic FLASH_SW_I,
    input wire logic LED_PWR_SW_I,
    // Shared boot sense pin, also card data-out
    input wire logic BOOT_SENSE_I,
    output logic BOOT_SENSE_O,
    output logic BOOT_SENSE_OE_O,
    // Card data-in and card detect pin
    input wire logic CARD_DATAIN_DETECT_I,
    output logic CARD_DATAIN_DETECT_O,
    output logic CARD_DATAIN_DETECT_OE_O,
    // Card select and clock pins
    output logic CARD_SELECT_N_O,
    output logic CARD_SELECT_OE_O,
    output logic CARD_CLOCK_O,
    output logic CARD_CLOCK_OE_O,
    // Loader drive for card pins (same clock)
    input wire logic LDR_CARD_DATAIN_I,
    input wire logic LDR_CARD_SELECT_N_I,
    input wire logic LDR_CARD_CLOCK_I,
    output logic CARD_DATAOUT_O,
    // Loader handshakes (same clock)
    input wire logic FLASH_OK_I,
    input wire logic FLASH_FAIL_I,
    input wire logic CARD_OK_I,
    input wire logic CARD_FAIL_I,
    input wire logic SER_LOADED_I,
    output logic FLASH_REQ_O,
    output logic [bms_pkg::FLASH_ADDR_W-1:0] FLASH_LAST_ADDR_O,
    output logic CARD_REQ_O,
    output logic SER_WIN_O,
    // Status
    output logic CORE_EN_O,
    output logic BOOT_PINS_OWNED_O,
    output logic BOOT_DONE_O,
    output logic SHUTDOWN_O,
    output bms_pkg::bms_state_t STATE_O,
    // LED pins in, LED drive out
    input wire logic LED_PIN_A_I,
    input wire logic LED_PIN_B_I,
    output logic LED_A_O,
    output logic LED_B_O
);
    import bms_pkg::*;

    bms_tmr_if tmr ();

    bms_timer u_timer (
        .clk_i (CLK_SYS_I),
        .rst_n_i (RST_N_I),
        .tmr (tmr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for all pin inputs
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {FLASH_SW_I, LED_PWR_SW_I, BOOT_SENSE_I,
                        CARD_DATAIN_DETECT_I, LED_PIN_A_I, LED_PIN_B_I};
            sync2_r <= sync1_r;
        end
    end

    logic flash_sw_s;
    logic led_pwr_s;
    logic sense_s;
    logic detect_s;
    logic led_a_s;
    logic led_b_s;
    assign {flash_sw_s, led_pwr_s, sense_s, detect_s, led_a_s, led_b_s} = sync2_r;

    ////////////////////////////////////////////////////////////////////////
    // Selection table; both up and down on is the host's fault and
    // is resolved as up, the safe serial-only choice
    function automatic bms_state_t first_step(input logic flash, input logic up,
                                              input logic down, input logic card);
        if (up)
            return ST_SER_LONG;                // see R03
        else if (flash && !down)
            return ST_SER_SHORT;               // see R04
        else if (flash)
            return ST_FLASH;                   // see R05
        else if (down)
            return ST_CARD;                    // see R07
        else if (card)
            return ST_CARD;                    // see R06
        else
            return ST_SER_LONG;                // see R02
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state and captured selection
    bms_state_t state_r;
    logic sel_flash_r;
    logic sel_up_r;
    logic sel_down_r;
    logic sel_card_r;
    logic tmr_start_r;
    logic [TMR_W-1:0] tmr_load_r;

    assign tmr.start = tmr_start_r;
    assign tmr.load = tmr_load_r;

    // Main sequence; a reset always lands back in ST_HOLD, see R01
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_r <= ST_HOLD;
            tmr_start_r <= 1'b1;
            tmr_load_r <= RESTART_CYC_P;
        end else begin
            tmr_start_r <= 1'b0;
            unique case (state_r)
                ST_HOLD: begin
                    // Cores wait out the restart delay, see R15
                    if (tmr.expired) begin
                        state_r <= ST_DRV_LO;
                        tmr_start_r <= 1'b1;
                        tmr_load_r <= PROBE_CYC;
                    end
                end
                ST_DRV_LO, ST_REL_LO, ST_DRV_HI: begin
                    if (tmr.expired) begin
                        state_r <= bms_state_t'(state_r + 4'h1);
                        tmr_start_r <= 1'b1;
                        tmr_load_r <= PROBE_CYC;
                    end
                end
                ST_REL_HI: begin
                    if (tmr.expired)
                        state_r <= ST_DECIDE;
                end
                ST_DECIDE: begin
                    state_r <= first_step(sel_flash_r, sel_up_r, sel_down_r, sel_card_r);
                    tmr_start_r <= 1'b1;
                    tmr_load_r <= (sel_flash_r && !sel_up_r && !sel_down_r) ?
                                  SER_SHORT_CYC_P : SER_LONG_CYC_P;
                end
                ST_SER_SHORT: begin
                    // Code that arrives in the short window wins over flash
                    if (SER_LOADED_I)
                        state_r <= ST_RUN;
                    else if (tmr.expired)
                        state_r <= ST_FLASH;           // see R04
                end
                ST_FLASH: begin
                    if (FLASH_OK_I) begin
                        state_r <= ST_RUN;
                    end else if (FLASH_FAIL_I) begin
                        state_r <= sel_down_r ? ST_SHUTDOWN : ST_SER_LONG; // see R04, R05
                        tmr_start_r <= 1'b1;
                        tmr_load_r <= SER_LONG_CYC_P;
                    end
                end
                ST_CARD: begin
                    if (CARD_OK_I) begin
                        state_r <= ST_RUN;
                    end else if (CARD_FAIL_I) begin
                        state_r <= sel_down_r ? ST_SHUTDOWN : ST_SER_LONG; // see R06, R07
                        tmr_start_r <= 1'b1;
                        tmr_load_r <= SER_LONG_CYC_P;
                    end
                end
                ST_SER_LONG: begin
                    // An empty long window ends in shutdown
                    if (SER_LOADED_I)
                        state_r <= ST_RUN;
                    else if (tmr.expired)
                        state_r <= ST_SHUTDOWN;
                end
                ST_RUN, ST_SHUTDOWN: begin
                    state_r <= state_r;
                end
                default: begin
                    state_r <= ST_SHUTDOWN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Switch capture: sense pin read once after each released probe
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sel_flash_r <= 1'b0;
            sel_up_r <= 1'b0;
            sel_down_r <= 1'b0;
            sel_card_r <= 1'b0;
        end else if (tmr.expired) begin
            // Pull-up holds the pin high after a low drive, see R08
            if (state_r == ST_REL_LO) begin
                sel_up_r <= sense_s;                   // see R16
                sel_flash_r <= flash_sw_s;
                sel_card_r <= detect_s;                // see R10
            end
            // Pull-down holds it low after a high drive, see R08
            if (state_r == ST_REL_HI)
                sel_down_r <= !sense_s;                // see R09
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive; everything floats in reset and after boot, see R15, R16
    logic card_phase;
    assign card_phase = (state_r == ST_CARD);

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            BOOT_SENSE_O <= 1'b0;
            BOOT_SENSE_OE_O <= 1'b0;
            CARD_DATAIN_DETECT_O <= 1'b0;
            CARD_DATAIN_DETECT_OE_O <= 1'b0;
            CARD_SELECT_N_O <= 1'b1;
            CARD_SELECT_OE_O <= 1'b0;
            CARD_CLOCK_O <= 1'b0;
            CARD_CLOCK_OE_O <= 1'b0;
            CARD_DATAOUT_O <= 1'b0;
        end else begin
            BOOT_SENSE_O <= (state_r == ST_DRV_HI);
            BOOT_SENSE_OE_O <= (state_r == ST_DRV_LO) || (state_r == ST_DRV_HI);
            CARD_DATAIN_DETECT_O <= LDR_CARD_DATAIN_I;                 // see R10
            CARD_DATAIN_DETECT_OE_O <= card_phase;
            CARD_SELECT_N_O <= card_phase ? LDR_CARD_SELECT_N_I : 1'b1; // see R10
            CARD_SELECT_OE_O <= card_phase;
            CARD_CLOCK_O <= card_phase & LDR_CARD_CLOCK_I;             // see R10
            CARD_CLOCK_OE_O <= card_phase;
            // Card answers on the sense pin while the card boots
            CARD_DATAOUT_O <= card_phase & sense_s;                   // see R10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status and loader requests, all registered
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            FLASH_REQ_O <= 1'b0;
            FLASH_LAST_ADDR_O <= '0;
            CARD_REQ_O <= 1'b0;
            SER_WIN_O <= 1'b0;
            CORE_EN_O <= 1'b0;
            BOOT_PINS_OWNED_O <= 1'b0;
            BOOT_DONE_O <= 1'b0;
            SHUTDOWN_O <= 1'b0;
            STATE_O <= ST_HOLD;
        end else begin
            FLASH_REQ_O <= (state_r == ST_FLASH);
            FLASH_LAST_ADDR_O <= FLASH_LAST_ADDR;                      // see R11
            CARD_REQ_O <= card_phase;
            SER_WIN_O <= (state_r == ST_SER_SHORT) || (state_r == ST_SER_LONG);
            CORE_EN_O <= (state_r != ST_HOLD) && (state_r != ST_SHUTDOWN); // see R15
            BOOT_PINS_OWNED_O <= (state_r != ST_HOLD) && (state_r != ST_RUN)
                                 && (state_r != ST_SHUTDOWN);          // see R16
            BOOT_DONE_O <= (state_r == ST_RUN);
            SHUTDOWN_O <= (state_r == ST_SHUTDOWN);                    // see R05
            STATE_O <= state_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // LED buffer: only reads the pins, never loads them
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            LED_A_O <= 1'b0;
            LED_B_O <= 1'b0;
        end else begin
            LED_A_O <= led_pwr_s & led_a_s;        // see R12, R13
            LED_B_O <= led_pwr_s & led_b_s;        // see R12, R13
        end
    end
endmodule

//--- bench/bms_far_model.sv
`timescale 1ns/100ps
module bms_far_model (
    // Clock and switch setup
    input wire logic clk_i,
    input wire logic up_i, down_i, card_i, fl_good_i, cd_good_i,
    // Pin drive from the device
    input wire logic sense_drv_i, sense_oe_i, det_drv_i, det_oe_i,
    // Loader requests
    input wire logic flash_req_i, card_req_i,
    // Resolved pins and loader results
    output logic sense_o, det_o,
    output logic flash_ok_o, flash_fail_o, card_ok_o, card_fail_o
);
    logic held_r;
    logic [1:0] dly_r;
    // Unpulled line keeps the charge of the last probe drive
    always_ff @(posedge clk_i) begin
        if (sense_oe_i) held_r <= sense_drv_i;
    end
    // Drive wins, else up pulls high and down pulls low
    assign sense_o = sense_oe_i ? sense_drv_i : up_i ? 1'b1 : down_i ? 1'b0 : held_r;
    // Detect reads high while a card sits in the socket
    assign det_o = det_oe_i ? det_drv_i : card_i;
    // Loader answers three cycles into a request
    always_ff @(negedge clk_i) begin
        if (!(flash_req_i || card_req_i)) dly_r <= 2'h0;
        else if (dly_r != 2'h3) dly_r <= dly_r + 2'h1;
    end
    // Failure only where the scenario asks for it
    assign flash_ok_o = flash_req_i && dly_r == 2'h3 && fl_good_i;
    assign flash_fail_o = flash_req_i && dly_r == 2'h3 && !fl_good_i;
    assign card_ok_o = card_req_i && dly_r == 2'h3 && cd_good_i;
    assign card_fail_o = card_req_i && dly_r == 2'h3 && !cd_good_i;
endmodule

//--- bench/bms_boot_ctrl_asserts.sv
`timescale 1ns/100ps
module bms_boot_ctrl_asserts
    import bms_pkg::*;
#(
    parameter logic [31:0] RESTART_CYC_P = 32'h14,
    parameter logic [31:0] SER_LONG_CYC_P = 32'h64
) (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    // Watched ports
    input wire logic LED_PWR_SW_I, LED_PIN_A_I, LED_PIN_B_I, LED_A_O, LED_B_O,
    input wire logic BOOT_SENSE_O, BOOT_SENSE_OE_O, CARD_DATAIN_DETECT_OE_O,
    input wire logic FLASH_OK_I, FLASH_REQ_O, CARD_REQ_O, SER_WIN_O, CORE_EN_O,
    input wire logic BOOT_PINS_OWNED_O, BOOT_DONE_O, SHUTDOWN_O,
    input wire logic CARD_SELECT_N_O, CARD_SELECT_OE_O, CARD_CLOCK_O, CARD_CLOCK_OE_O,
    input wire logic [23:0] FLASH_LAST_ADDR_O,
    input bms_state_t STATE_O
);
    logic [31:0] since_r;
    logic [31:0] win_r;
    // Cycles since reset release, saturating
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) since_r <= 32'h0;
        else if (since_r != 32'hffff_ffff) since_r <= since_r + 32'h1;
    end
    // Length of the open serial window
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) win_r <= 32'h0;
        else win_r <= SER_WIN_O ? win_r + 32'h1 : 32'h0;
    end
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    ////////////////////////////////////////////////////////////////////////////
    chk_led_a_path: assert property (since_r > 32'h3 |->
        LED_A_O == $past(LED_PWR_SW_I && LED_PIN_A_I, 3)) else $error("led a path");
    chk_led_b_path: assert property (since_r > 32'h3 |->
        LED_B_O == $past(LED_PWR_SW_I && LED_PIN_B_I, 3)) else $error("led b path");
    chk_hold_cores_off: assert property (since_r < RESTART_CYC_P |->
        STATE_O == ST_HOLD && !CORE_EN_O) else $error("restart hold too short");
    chk_hold_ends: assert property (since_r == RESTART_CYC_P + 32'h1e |->
        STATE_O != ST_HOLD) else $error("restart hold too long");
    // Timer start is registered, so a window runs two cycles past its count
    chk_window_bound: assert property (win_r <= SER_LONG_CYC_P + 32'h2)
        else $error("serial window too long");
    chk_flash_ok_done: assert property (FLASH_REQ_O && FLASH_OK_I |-> ##2
        BOOT_DONE_O && !FLASH_REQ_O) else $error("flash success not taken");
    chk_shut_sticky: assert property (SHUTDOWN_O |=> SHUTDOWN_O && !BOOT_DONE_O)
        else $error("shutdown left");
    chk_done_pins_free: assert property (BOOT_DONE_O |-> !BOOT_PINS_OWNED_O ##1
        BOOT_DONE_O) else $error("pins held after boot");
    chk_probe_low: assert property (STATE_O == ST_DRV_LO |->
        BOOT_SENSE_OE_O && !BOOT_SENSE_O) else $error("low probe drive");
    chk_probe_high: assert property (STATE_O == ST_DRV_HI |->
        BOOT_SENSE_OE_O && BOOT_SENSE_O) else $error("high probe drive");
    chk_card_pin_own: assert property (CARD_DATAIN_DETECT_OE_O |->
        STATE_O == ST_CARD) else $error("card pin driven outside card boot");
    chk_card_pins_idle: assert property (STATE_O != ST_CARD |->
        CARD_SELECT_N_O && !CARD_SELECT_OE_O && !CARD_CLOCK_O && !CARD_CLOCK_OE_O)
        else $error("card select or clock active outside card boot");
    chk_flash_size: assert property (since_r > 32'h1 |->
        FLASH_LAST_ADDR_O == 24'hff_ffff) else $error("flash size");
    cov_done: cover property ($rose(BOOT_DONE_O));
    cov_shut: cover property ($rose(SHUTDOWN_O));
    cov_card: cover property ($rose(CARD_REQ_O));
endmodule
bind bms_boot_ctrl bms_boot_ctrl_asserts #(.RESTART_CYC_P(RESTART_CYC_P),
    .SER_LONG_CYC_P(SER_LONG_CYC_P)) chk_u (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
    .LED_PWR_SW_I(LED_PWR_SW_I), .LED_PIN_A_I(LED_PIN_A_I), .LED_PIN_B_I(LED_PIN_B_I),
    .LED_A_O(LED_A_O), .LED_B_O(LED_B_O), .BOOT_SENSE_O(BOOT_SENSE_O),
    .BOOT_SENSE_OE_O(BOOT_SENSE_OE_O), .CARD_DATAIN_DETECT_OE_O(CARD_DATAIN_DETECT_OE_O),
    .FLASH_OK_I(FLASH_OK_I), .FLASH_REQ_O(FLASH_REQ_O), .CARD_REQ_O(CARD_REQ_O),
    .SER_WIN_O(SER_WIN_O), .CORE_EN_O(CORE_EN_O), .BOOT_PINS_OWNED_O(BOOT_PINS_OWNED_O),
    .BOOT_DONE_O(BOOT_DONE_O), .SHUTDOWN_O(SHUTDOWN_O),
    .CARD_SELECT_N_O(CARD_SELECT_N_O), .CARD_SELECT_OE_O(CARD_SELECT_OE_O),
    .CARD_CLOCK_O(CARD_CLOCK_O), .CARD_CLOCK_OE_O(CARD_CLOCK_OE_O),
    .FLASH_LAST_ADDR_O(FLASH_LAST_ADDR_O), .STATE_O(STATE_O));

//--- bench/tb.sv
`timescale 1ns/100ps
module tb;
    import bms_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic fl_sw = 1'b0, led_sw = 1'b0, pin_a = 1'b0, pin_b = 1'b0, ser_ld = 1'b0;
    logic up = 1'b0, down = 1'b0, card = 1'b0, fl_good = 1'b0, cd_good = 1'b0;
    logic ld_mode = 1'b0, ldr = 1'b1;
    logic sense, det, fl_ok, fl_fail, cd_ok, cd_fail, s_drv, s_oe, d_drv, d_oe;
    logic fl_req, cd_req, win, done, shut, core, led_a, led_b;
    logic [23:0] last_addr;
    bms_state_t state;
    int num_errors = 0;
    int num_checks = 0;
    // Short counts keep each boot to a few hundred cycles
    bms_boot_ctrl #(.RESTART_CYC_P(32'h14), .SER_SHORT_CYC_P(32'h32),
        .SER_LONG_CYC_P(32'h64)) dut_u (.CLK_SYS_I(clk), .RST_N_I(rst_n),
        .FLASH_SW_I(fl_sw), .LED_PWR_SW_I(led_sw), .BOOT_SENSE_I(sense),
        .BOOT_SENSE_O(s_drv), .BOOT_SENSE_OE_O(s_oe), .CARD_DATAIN_DETECT_I(det),
        .CARD_DATAIN_DETECT_O(d_drv), .CARD_DATAIN_DETECT_OE_O(d_oe),
        .CARD_SELECT_N_O(), .CARD_SELECT_OE_O(), .CARD_CLOCK_O(), .CARD_CLOCK_OE_O(),
        .LDR_CARD_DATAIN_I(ldr), .LDR_CARD_SELECT_N_I(!ldr), .LDR_CARD_CLOCK_I(ldr),
        .CARD_DATAOUT_O(), .FLASH_OK_I(fl_ok), .FLASH_FAIL_I(fl_fail), .CARD_OK_I(cd_ok),
        .CARD_FAIL_I(cd_fail), .SER_LOADED_I(ser_ld), .FLASH_REQ_O(fl_req),
        .FLASH_LAST_ADDR_O(last_addr), .CARD_REQ_O(cd_req), .SER_WIN_O(win),
        .CORE_EN_O(core), .BOOT_PINS_OWNED_O(), .BOOT_DONE_O(done), .SHUTDOWN_O(shut),
        .STATE_O(state), .LED_PIN_A_I(pin_a), .LED_PIN_B_I(pin_b), .LED_A_O(led_a),
        .LED_B_O(led_b));
    bms_far_model far_u (.clk_i(clk), .up_i(up), .down_i(down), .card_i(card),
        .fl_good_i(fl_good), .cd_good_i(cd_good), .sense_drv_i(s_drv), .sense_oe_i(s_oe),
        .det_drv_i(d_drv), .det_oe_i(d_oe), .flash_req_i(fl_req), .card_req_i(cd_req),
        .sense_o(sense), .det_o(det), .flash_ok_o(fl_ok), .flash_fail_o(fl_fail),
        .card_ok_o(cd_ok), .card_fail_o(cd_fail));
    ////////////////////////////////////////////////////////////////////////////
    // Clock, 100 ns period
    initial begin
        forever #50 clk = !clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Reset may land in the middle of a boot
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        check("state in reset", 32'(state), 32'(ST_HOLD));
        check("cores in reset", {31'h0, core}, 32'h0);
        rst_n = 1'b1;
    endtask
    // cfg: flash, up, down, card, flash good, card good, serial load
    task automatic run_case(input logic [6:0] cfg, input logic [31:0] ewin,
        input logic [2:0] exp);
        logic [31:0] nwin;
        logic fl_seen;
        logic cd_seen;
        int i;
        {fl_sw, up, down, card, fl_good, cd_good, ld_mode} = cfg;
        nwin = 32'h0;
        fl_seen = 1'b0;
        cd_seen = 1'b0;
        ser_ld = 1'b0;
        do_reset();
        for (i = 0; i < 2000 && done !== 1'b1 && shut !== 1'b1; i++) begin
            @(negedge clk);
            nwin += {31'h0, win};
            fl_seen |= fl_req;
            cd_seen |= cd_req;
            ser_ld = ld_mode && win;
            ldr = !ldr;
            // Switch moved after sampling must not matter
            if (win || fl_req || cd_req) fl_sw = !cfg[6];
        end
        if (i >= 2000) begin
            check("boot finished", 32'h0, 32'h1);
            close_out();
        end
        if (ewin != 32'hffff_ffff) check("window cycles", nwin, ewin);
        check("flash card done", {29'h0, fl_seen, cd_seen, done}, {29'h0, exp});
        check("shutdown", {31'h0, shut}, {31'h0, !exp[0]});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        fl_sw = 1'b1;
        do_reset();
        repeat (60) @(negedge clk);
        check("flash size", {8'h0, last_addr}, 32'h00ff_ffff);
        // A window spans its count plus two cycles of timer start latency
        run_case(7'b0000000, 32'd102, 3'b000);
        run_case(7'b1101110, 32'd102, 3'b000);
        run_case(7'b0100001, 32'hffff_ffff, 3'b001);
        run_case(7'b1000000, 32'd154, 3'b100);
        run_case(7'b1000100, 32'd52, 3'b101);
        run_case(7'b1010000, 32'd0, 3'b100);
        run_case(7'b0001000, 32'd102, 3'b010);
        run_case(7'b0001010, 32'd0, 3'b011);
        run_case(7'b0011010, 32'd0, 3'b011);
        run_case(7'b0011000, 32'd0, 3'b010);
        run_case(7'b0000001, 32'hffff_ffff, 3'b001);
        // LED pins held at defined levels, every switch combination
        for (int k = 0; k < 8; k++) begin
            {led_sw, pin_a, pin_b} = 3'(k);
            repeat (4) @(negedge clk);
            check("led a", {31'h0, led_a}, {31'h0, led_sw & pin_a});
            check("led b", {31'h0, led_b}, {31'h0, led_sw & pin_b});
        end
        close_out();
    end
endmodule
